/* File: common/reset_seq_pkg.sv */
// Constants and types for the reset source and initial state sequencer
package reset_seq_pkg;

  // ===========================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ===========================================================
  // Register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PSW = 14'h0000;
  localparam logic [IDX_W-1:0] IDX_BANK = 14'h0001;
  localparam logic [IDX_W-1:0] IDX_INTV = 14'h0002;
  localparam logic [IDX_W-1:0] IDX_TMR0 = 14'h0003;
  localparam logic [IDX_W-1:0] IDX_TMR2X = 14'h0006;
  localparam logic [IDX_W-1:0] IDX_CLK = 14'h0007;
  localparam logic [IDX_W-1:0] IDX_IRQ = 14'h0008;
  localparam logic [IDX_W-1:0] IDX_PORT = 14'h0009;
  localparam logic [IDX_W-1:0] IDX_BSB = 14'h000a;
  localparam logic [IDX_W-1:0] IDX_STAT = 14'h000b;
  localparam logic [IDX_W-1:0] IDX_CTRL = 14'h000c;
  localparam logic [IDX_W-1:0] IDX_CAUSE = 14'h0fc6;
  localparam int NUM_TMR = 3;

  // ===========================================================
  // Field positions
  localparam int PSW_CARRY = 0;
  localparam int PSW_RBE = 6;
  localparam int PSW_MBE = 7;
  localparam int CAUSE_WDF = 2;
  localparam int CAUSE_KRF = 3;
  localparam int STAT_RUN = 0;
  localparam int STAT_NVU = 1;
  localparam int STAT_STBY = 2;
  localparam int CTRL_KEY_EN = 0;
  localparam int VEC_NIB_W = 4;
  localparam int PC_W = 12;
  localparam int PM_W = 8;
  localparam int PORT_OE_W = 8;
  localparam int KEY_W = 4;

  // ===========================================================
  // Reset values
  localparam logic [DATA_W-1:0] PSW_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PSW_KEEP_MASK = 32'h0000_0001;
  localparam logic [DATA_W-1:0] BANK_RST = 32'h0000_0008;
  localparam logic [DATA_W-1:0] INTV_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TMR_RST = 32'h0000_ff00;
  localparam logic [DATA_W-1:0] TMR2X_RST = 32'h0000_00ff;
  localparam logic [DATA_W-1:0] CLK_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IRQ_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PORT_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BSB_RST = 32'h0000_0000;
  localparam logic [PC_W-1:0] VEC_ADDR_HI = 12'h000;
  localparam logic [PC_W-1:0] VEC_ADDR_LO = 12'h001;

  // ===========================================================
  // Timing, in main oscillator periods (one sys_clk each)
  localparam int WAIT_LONG_PERIODS = 2 ** 17;
  localparam int WAIT_SHORT_PERIODS = 2 ** 15;
  localparam int WAIT_LOWF_PERIODS = 56;
  localparam int CNT_W = 18;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_WAIT,
    ST_VEC_HI,
    ST_VEC_LO,
    ST_RUN
  } seq_state_t;

endpackage : reset_seq_pkg

/* File: core/reset_seq.sv */
// Reset source combiner, oscillation wait, vector fetch and initial state
`timescale 1ns/100ps
`default_nettype none

module reset_seq #(
  parameter bit LOW_FREQ_VARIANT = 1'b0,
  parameter bit LONG_WAIT = 1'b1,
  parameter int WAIT_LONG_CYCLES = reset_seq_pkg::WAIT_LONG_PERIODS,
  parameter int WAIT_SHORT_CYCLES = reset_seq_pkg::WAIT_SHORT_PERIODS
) (
  // Clock and system reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Reset sources
  input wire logic reset_pin_n_i,
  input wire logic watchdog_overflow_i,
  input wire logic [reset_seq_pkg::KEY_W-1:0] key_input_i,
  // Core status
  input wire logic stop_mode_i,
  input wire logic halt_mode_i,
  input wire logic nv_write_busy_i,
  // Program memory vector read
  output logic [reset_seq_pkg::PC_W-1:0] pm_addr_o,
  input wire logic [reset_seq_pkg::PM_W-1:0] pm_data_i,
  // Sequencer results
  output logic internal_reset_o,
  output logic cpu_run_o,
  output logic [reset_seq_pkg::PC_W-1:0] pc_o,
  output logic reg_bank_enable_o,
  output logic mem_bank_enable_o,
  output logic state_retained_o,
  output logic nv_data_undefined_o,
  output logic [reset_seq_pkg::PORT_OE_W-1:0] port_out_enable_o,
  // AXI4-Lite slave
  input wire logic [reset_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [reset_seq_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [reset_seq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [reset_seq_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import reset_seq_pkg::*;

  // ===========================================================
  // Wait length
  localparam int WAIT_CYCLES = LOW_FREQ_VARIANT ? WAIT_LOWF_PERIODS :
                               (LONG_WAIT ? WAIT_LONG_CYCLES : WAIT_SHORT_CYCLES);
  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WAIT_CYCLES - 1);

  // ===========================================================
  // State
  typedef struct packed {
    seq_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] pm_addr;
    logic [DATA_W-1:0] psw;
    logic [DATA_W-1:0] bank;
    logic [DATA_W-1:0] intv;
    logic [NUM_TMR-1:0][DATA_W-1:0] tmr;
    logic [DATA_W-1:0] tmr2x;
    logic [DATA_W-1:0] clk;
    logic [DATA_W-1:0] irq;
    logic [DATA_W-1:0] port;
    logic [DATA_W-1:0] bsb;
    logic key_en;
    logic watchdog_cause_flag;
    logic key_cause_flag;
    logic nv_undef;
    logic standby;
    logic pin_s1;
    logic pin_s2;
    logic [KEY_W-1:0] key_s1;
    logic [KEY_W-1:0] key_s2;
    logic [KEY_W-1:0] key_prev;
    logic key_pulse;
    logic aw_ok;
    logic [ADDR_W-1:0] aw_addr;
    logic w_ok;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } seq_t;

  seq_t state_reg;
  seq_t state_next;

  // ===========================================================
  // Helpers
  function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] wd,
                                                  input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction : word_idx

  function automatic logic is_tmr(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_TMR0) && (idx < IDX_TMR0 + IDX_W'(NUM_TMR));
  endfunction : is_tmr

  // ===========================================================
  // Next state
  logic src_ext;
  logic src_any;
  logic standby_now;
  logic [IDX_W-1:0] widx;
  logic [IDX_W-1:0] ridx;
  logic w_hit;
  logic do_write;
  logic do_read;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] cause_word;
  logic [DATA_W-1:0] stat_word;

  always_comb begin
    state_next = state_reg;
    widx = word_idx(state_reg.aw_addr);
    ridx = word_idx(s_axi_araddr);
    cause_word = '0;
    cause_word[CAUSE_WDF] = state_reg.watchdog_cause_flag;
    cause_word[CAUSE_KRF] = state_reg.key_cause_flag;
    stat_word = '0;
    stat_word[STAT_RUN] = (state_reg.st == ST_RUN);
    stat_word[STAT_NVU] = state_reg.nv_undef;
    stat_word[STAT_STBY] = state_reg.standby;

    // Pin synchronisers; first stage feeds only the second
    state_next.pin_s1 = reset_pin_n_i;
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.key_s1 = key_input_i;
    state_next.key_s2 = state_reg.key_s1;
    state_next.key_prev = state_reg.key_s2;
    // Falling edge on any key, only while armed and stopped
    state_next.key_pulse = state_reg.key_en && stop_mode_i &&
                           |(state_reg.key_prev & ~state_reg.key_s2);

    src_ext = ~state_reg.pin_s2;
    src_any = src_ext || watchdog_overflow_i || state_reg.key_pulse;
    standby_now = (state_reg.st == ST_RESET) ? state_reg.standby : (stop_mode_i || halt_mode_i);

    // AXI write path: address and data taken in either order
    do_write = state_reg.aw_ok && state_reg.w_ok && !state_reg.bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_ok = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_ok = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    w_hit = 1'b1;
    if (do_write) begin
      state_next.aw_ok = 1'b0;
      state_next.w_ok = 1'b0;
      state_next.bvalid = 1'b1;
      if (widx == IDX_PSW) begin
        state_next.psw = merge_strb(state_reg.psw, state_reg.w_data, state_reg.w_strb);
      end else if (widx == IDX_BANK) begin
        state_next.bank = merge_strb(state_reg.bank, state_reg.w_data, state_reg.w_strb);
      end else if (widx == IDX_INTV) begin
        state_next.intv = merge_strb(state_reg.intv, state_reg.w_data, state_reg.w_strb);
      end else if (is_tmr(widx)) begin
        for (int t = 0; t < NUM_TMR; t++) begin
          if (widx == IDX_TMR0 + IDX_W'(t)) begin
            state_next.tmr[t] = merge_strb(state_reg.tmr[t], state_reg.w_data,
                                           state_reg.w_strb);
          end
        end
      end else if (widx == IDX_TMR2X) begin
        state_next.tmr2x = merge_strb(state_reg.tmr2x, state_reg.w_data, state_reg.w_strb);
      end else if (widx == IDX_CLK) begin
        state_next.clk = merge_strb(state_reg.clk, state_reg.w_data, state_reg.w_strb);
      end else if (widx == IDX_IRQ) begin
        state_next.irq = merge_strb(state_reg.irq, state_reg.w_data, state_reg.w_strb);
      end else if (widx == IDX_PORT) begin
        state_next.port = merge_strb(state_reg.port, state_reg.w_data, state_reg.w_strb);
      end else if (widx == IDX_BSB) begin
        state_next.bsb = merge_strb(state_reg.bsb, state_reg.w_data, state_reg.w_strb);
      end else if (widx == IDX_CTRL) begin
        if (state_reg.w_strb[0]) begin
          state_next.key_en = state_reg.w_data[CTRL_KEY_EN];
        end
      end else if (widx == IDX_STAT) begin
        // Write one to acknowledge the undefined-data warning
        if (state_reg.w_strb[0] && state_reg.w_data[STAT_NVU]) begin
          state_next.nv_undef = 1'b0;
        end
      end else if (widx == IDX_CAUSE) begin
        // Software clear instruction, write one to clear
        if (state_reg.w_strb[0] && state_reg.w_data[CAUSE_WDF]) begin
          state_next.watchdog_cause_flag = 1'b0;
        end
        if (state_reg.w_strb[0] && state_reg.w_data[CAUSE_KRF]) begin
          state_next.key_cause_flag = 1'b0;
        end
      end else begin
        w_hit = 1'b0;
      end
      state_next.bresp = w_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // AXI read path, one cycle to rvalid
    do_read = s_axi_arvalid && !state_reg.rvalid;
    rd_val = '0;
    state_next.rresp = state_reg.rresp;
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (do_read) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      case (ridx)
        IDX_PSW: rd_val = state_reg.psw;
        IDX_BANK: rd_val = state_reg.bank;
        IDX_INTV: rd_val = state_reg.intv;
        IDX_TMR2X: rd_val = state_reg.tmr2x;
        IDX_CLK: rd_val = state_reg.clk;
        IDX_IRQ: rd_val = state_reg.irq;
        IDX_PORT: rd_val = state_reg.port;
        IDX_BSB: rd_val = state_reg.bsb;
        IDX_STAT: rd_val = stat_word;
        IDX_CTRL: rd_val = {{(DATA_W-1){1'b0}}, state_reg.key_en};
        IDX_CAUSE: rd_val = cause_word;
        default: begin
          if (is_tmr(ridx)) begin
            rd_val = state_reg.tmr[ridx - IDX_TMR0];
          end else begin
            state_next.rresp = RESP_SLVERR;
          end
        end
      endcase
      state_next.rdata = rd_val;
    end

    // Sequencer
    case (state_reg.st)
      ST_WAIT: begin
        if (state_reg.cnt == WAIT_LAST) begin
          state_next.st = ST_VEC_HI;
          state_next.pm_addr = VEC_ADDR_HI;
        end else begin
          state_next.cnt = state_reg.cnt + CNT_W'(1);
        end
      end
      ST_VEC_HI: begin
        state_next.pc[PC_W-1 -: VEC_NIB_W] = pm_data_i[VEC_NIB_W-1:0];
        state_next.psw[PSW_RBE] = pm_data_i[PSW_RBE];
        state_next.psw[PSW_MBE] = pm_data_i[PSW_MBE];
        state_next.pm_addr = VEC_ADDR_LO;
        state_next.st = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        state_next.pc[PM_W-1:0] = pm_data_i;
        state_next.st = ST_RUN;
      end
      ST_RUN: begin
        state_next.st = ST_RUN;
      end
      ST_RESET: begin
        if (!src_any) begin
          state_next.st = ST_WAIT;
          state_next.cnt = '0;
        end
      end
      default: begin
        state_next.st = ST_RESET;
      end
    endcase

    // Any reset source overrides the sequencer and writes
    if (src_any) begin
      state_next.st = ST_RESET;
      state_next.cnt = '0;
      state_next.standby = standby_now;
      if (nv_write_busy_i && state_reg.st != ST_RESET) begin
        state_next.nv_undef = 1'b1;
      end
      // Carry kept only when reset came in standby; else cleared
      state_next.psw = standby_now ? (state_reg.psw & PSW_KEEP_MASK) : PSW_RST;
      state_next.bank = BANK_RST;
      state_next.intv = INTV_RST;
      for (int t = 0; t < NUM_TMR; t++) begin
        state_next.tmr[t] = TMR_RST;
      end
      state_next.tmr2x = TMR2X_RST;
      state_next.clk = CLK_RST;
      state_next.irq = IRQ_RST;
      state_next.port = PORT_RST;
      state_next.bsb = standby_now ? state_reg.bsb : BSB_RST;
      state_next.key_en = 1'b0;
      state_next.pc = '0;
      // Hardware setting wins over a software clear in the same cycle
      if (src_ext) begin
        state_next.watchdog_cause_flag = 1'b0;
        state_next.key_cause_flag = 1'b0;
      end else begin
        if (watchdog_overflow_i) begin
          state_next.watchdog_cause_flag = 1'b1;
        end
        if (state_reg.key_pulse) begin
          state_next.key_cause_flag = 1'b1;
        end
      end
    end
  end

  // ===========================================================
  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
      state_reg.st <= ST_RESET;
      state_reg.pin_s1 <= 1'b1;
      state_reg.pin_s2 <= 1'b1;
      state_reg.key_s1 <= '1;
      state_reg.key_s2 <= '1;
      state_reg.key_prev <= '1;
      state_reg.bank <= BANK_RST;
      for (int t = 0; t < NUM_TMR; t++) begin
        state_reg.tmr[t] <= TMR_RST;
      end
      state_reg.tmr2x <= TMR2X_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ===========================================================
  // Outputs
  assign internal_reset_o = (state_reg.st != ST_RUN);
  assign cpu_run_o = (state_reg.st == ST_RUN);
  assign pm_addr_o = state_reg.pm_addr;
  assign pc_o = state_reg.pc;
  assign reg_bank_enable_o = state_reg.psw[PSW_RBE];
  assign mem_bank_enable_o = state_reg.psw[PSW_MBE];
  assign state_retained_o = state_reg.standby;
  assign nv_data_undefined_o = state_reg.nv_undef;
  assign port_out_enable_o = state_reg.port[PORT_OE_W-1:0];
  assign s_axi_awready = !state_reg.aw_ok && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_ok && !state_reg.bvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

endmodule : reset_seq

`default_nettype wire

/* File: sim/vector_rom.sv */
// Program memory model answering the reset vector fetch
`timescale 1ns/100ps
`default_nettype none

module vector_rom #(
  parameter logic [7:0] WORD0 = 8'h4a,
  parameter logic [7:0] WORD1 = 8'h5c
) (
  // Fetch port
  input wire logic [11:0] addr_i,
  output logic [7:0] data_o
);
  // ====================
  // Read path
  // Other words give a scrambled pattern of the low address byte; with the default words, low bytes 8'h86 and 8'h90 still return WORD0 and WORD1
  always_comb begin
    if (addr_i == 12'h000) begin
      data_o = WORD0;
    end else if (addr_i == 12'h001) begin
      data_o = WORD1;
    end else begin
      data_o = ~addr_i[7:0] ^ 8'h33;
    end
  end
endmodule : vector_rom

`default_nettype wire

/* File: sim/reset_seq_assertions.sv */
// Port-level checks of the reset sequencer
`timescale 1ns/100ps
`default_nettype none

module reset_seq_assertions #(
  parameter bit LOW_FREQ_VARIANT = 1'b0,
  parameter bit LONG_WAIT = 1'b1,
  parameter int WAIT_LONG_CYCLES = 16,
  parameter int WAIT_SHORT_CYCLES = 8
) (
  // Clock, reset and sources
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic reset_pin_n_i,
  input wire logic watchdog_overflow_i,
  input wire logic nv_write_busy_i,
  // Vector fetch
  input wire logic [11:0] pm_addr_o,
  input wire logic [7:0] pm_data_i,
  // Results
  input wire logic internal_reset_o,
  input wire logic cpu_run_o,
  input wire logic [11:0] pc_o,
  input wire logic reg_bank_enable_o,
  input wire logic mem_bank_enable_o,
  input wire logic nv_data_undefined_o,
  input wire logic [7:0] port_out_enable_o
);
  localparam int W = LOW_FREQ_VARIANT ? 56 : (LONG_WAIT ? WAIT_LONG_CYCLES : WAIT_SHORT_CYCLES);
  logic [19:0] quiet_cnt;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ====================
  // Reset cycles since the last pin or watchdog source
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !reset_pin_n_i || watchdog_overflow_i || !internal_reset_o) begin
      quiet_cnt <= '0;
    end else begin
      quiet_cnt <= quiet_cnt + 20'h00001;
    end
  end

  // ====================
  // Properties
  chk_pin_src: assert property (
    !reset_pin_n_i [*3] |-> ##[1:2] internal_reset_o)
    else $error("pin reset missed");
  chk_wdog_src: assert property (
    watchdog_overflow_i |-> ##[1:2] internal_reset_o)
    else $error("watchdog reset missed");
  chk_run_excl: assert property (
    cpu_run_o |-> !internal_reset_o)
    else $error("running while in reset");
  chk_wait_len: assert property (
    $rose(cpu_run_o) |-> quiet_cnt >= W + 2 && quiet_cnt <= W + 8)
    else $error("stabilization wait length wrong");
  chk_vec_addr: assert property (
    $rose(cpu_run_o) |-> $past(pm_addr_o, 2) == 12'h000 && $past(pm_addr_o) == 12'h001)
    else $error("vector words fetched out of order");
  chk_pc_load: assert property (
    $rose(cpu_run_o) |-> pc_o == {$past(pm_data_i[3:0], 2), $past(pm_data_i)})
    else $error("start address wrong");
  chk_bank_en: assert property (
    $rose(cpu_run_o) |-> reg_bank_enable_o == $past(pm_data_i[6], 2)
      && mem_bank_enable_o == $past(pm_data_i[7], 2))
    else $error("bank enables wrong");
  chk_port_off: assert property (
    internal_reset_o && $past(internal_reset_o) |-> port_out_enable_o == 8'h00)
    else $error("port buffer on in reset");
  chk_nv_cause: assert property (
    $rose(nv_data_undefined_o) |-> $past(nv_write_busy_i) || $past(nv_write_busy_i, 2)
      || $past(nv_write_busy_i, 3))
    else $error("nonvolatile flag without write");
endmodule : reset_seq_assertions

bind reset_seq reset_seq_assertions #(
  .LOW_FREQ_VARIANT(LOW_FREQ_VARIANT),
  .LONG_WAIT(LONG_WAIT),
  .WAIT_LONG_CYCLES(WAIT_LONG_CYCLES),
  .WAIT_SHORT_CYCLES(WAIT_SHORT_CYCLES)
) chk_u (.*);

`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the reset sequencer
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import reset_seq_pkg::*;
  localparam logic [7:0] W0 = 8'h4a;
  localparam logic [7:0] W1 = 8'h5c;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic reset_pin_n_i = 1'b1;
  logic watchdog_overflow_i = 1'b0;
  logic [3:0] key_input_i = 4'hf;
  logic stop_mode_i = 1'b0;
  logic halt_mode_i = 1'b0;
  logic lf_rstn = 1'b0;
  logic lf_run;
  logic [11:0] lf_addr;
  logic [7:0] lf_data;
  logic nv_write_busy_i = 1'b0;
  logic [11:0] pm_addr_o, pc_o;
  logic [7:0] pm_data_i, port_out_enable_o;
  logic internal_reset_o, cpu_run_o, reg_bank_enable_o, mem_bank_enable_o;
  logic state_retained_o, nv_data_undefined_o;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int error_cnt = 0;
  int checked = 0;
  // Rows: register byte address beside its value after a reset in operation
  logic [15:0] ra [12] = '{16'h0000, 16'h0004, 16'h0008, 16'h000c, 16'h0010, 16'h0014,
                           16'h0018, 16'h001c, 16'h0020, 16'h0024, 16'h0028, 16'h0030};
  logic [31:0] rv [12] = '{{24'h0, W0[7:6], 6'h00}, BANK_RST, INTV_RST, TMR_RST, TMR_RST,
                           TMR_RST, TMR2X_RST, CLK_RST, IRQ_RST, PORT_RST, BSB_RST, 32'h0};

  reset_seq #(.WAIT_LONG_CYCLES(16), .WAIT_SHORT_CYCLES(8)) dut_u (.*);
  vector_rom #(.WORD0(W0), .WORD1(W1)) rom_u (.addr_i(pm_addr_o), .data_o(pm_data_i));
  // Low-frequency variant on a reset of its own, released once at the end
  reset_seq #(.LOW_FREQ_VARIANT(1'b1)) lowf_u (
    .sys_clk_i(sys_clk_i), .rstn_i(lf_rstn), .reset_pin_n_i(reset_pin_n_i),
    .watchdog_overflow_i(watchdog_overflow_i), .key_input_i(key_input_i),
    .stop_mode_i(stop_mode_i), .halt_mode_i(halt_mode_i), .nv_write_busy_i(nv_write_busy_i),
    .pm_addr_o(lf_addr), .pm_data_i(lf_data), .internal_reset_o(), .cpu_run_o(lf_run),
    .pc_o(), .reg_bank_enable_o(), .mem_bank_enable_o(), .state_retained_o(),
    .nv_data_undefined_o(), .port_out_enable_o(), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(s_axi_rready));
  vector_rom #(.WORD0(W0), .WORD1(W1)) lf_rom_u (.addr_i(lf_addr), .data_o(lf_data));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // ====================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Ready and valid are judged on the pre-edge values
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // No own limit: only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk($sformatf("reg %h", a), d, e);
  endtask : rd_chk

  task automatic wait_run;
    repeat (8) @(posedge sys_clk_i);
    for (int n = 0; n < 300 && cpu_run_o !== 1'b1; n++) @(posedge sys_clk_i);
    chk("run", cpu_run_o, 1);
  endtask : wait_run

  task automatic pin_rst;
    reset_pin_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    chk("reset", internal_reset_o, 1);
    reset_pin_n_i <= 1'b1;
    wait_run();
  endtask : pin_rst

  // ====================
  // Tests
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge sys_clk_i);
    chk("reset", internal_reset_o, 1);
    rstn_i <= 1'b1;
    wait_run();
    chk("pc", pc_o, {W0[3:0], W1});
    chk("bank en", {mem_bank_enable_o, reg_bank_enable_o}, W0[7:6]);
    foreach (ra[i]) axi_wr(ra[i], 32'hffff_ffff, r);
    pin_rst();
    chk("port oe", port_out_enable_o, 0);
    chk("standby", state_retained_o, 0);
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    $display("test reset values done");
    axi_wr(16'h0000, 32'h1, r);
    axi_wr(16'h0028, 32'h3c5a, r);
    halt_mode_i <= 1'b1;
    pin_rst();
    halt_mode_i <= 1'b0;
    chk("standby", state_retained_o, 1);
    rd_chk(16'h0000, {24'h0, W0[7:6], 6'h01});
    rd_chk(16'h0028, 32'h3c5a);
    $display("test standby done");
    stop_mode_i <= 1'b1;
    key_input_i <= 4'h7;
    repeat (10) @(posedge sys_clk_i);
    chk("run", cpu_run_o, 1);
    key_input_i <= 4'hf;
    axi_wr(16'h0030, 32'h1, r);
    key_input_i <= 4'he;
    wait_run();
    chk("standby", state_retained_o, 1);
    stop_mode_i <= 1'b0;
    key_input_i <= 4'hf;
    rd_chk(16'h3f18, 32'h8);
    watchdog_overflow_i <= 1'b1;
    @(posedge sys_clk_i);
    watchdog_overflow_i <= 1'b0;
    wait_run();
    rd_chk(16'h3f18, 32'hc);
    axi_wr(16'h3f18, 32'h4, r);
    rd_chk(16'h3f18, 32'h8);
    pin_rst();
    rd_chk(16'h3f18, 32'h0);
    $display("test cause flags done");
    nv_write_busy_i <= 1'b1;
    pin_rst();
    nv_write_busy_i <= 1'b0;
    chk("nv", nv_data_undefined_o, 1);
    axi_wr(16'h002c, 32'h2, r);
    @(posedge sys_clk_i);
    chk("nv", nv_data_undefined_o, 0);
    axi_wr(16'h0100, 32'h5, r);
    chk("bresp", r, RESP_SLVERR);
    axi_rd(16'h0100, d, r);
    chk("rresp", r, RESP_SLVERR);
    $display("test nonvolatile and unmapped done");
    lf_rstn <= 1'b1;
    repeat (WAIT_LOWF_PERIODS + 3) @(posedge sys_clk_i);
    chk("lowf early", lf_run, 0);
    @(posedge sys_clk_i);
    chk("lowf run", lf_run, 1);
    $display("test low-frequency wait done");
    end_sim();
  end

  initial begin
    #(4000 * 50);
    error_cnt++;
    end_sim();
  end
endmodule : testbench

`default_nettype wire
